// *** hw/seis_eeprom_slave.sv ***
/*
 * Two-wire serial EEPROM slave: condition detection, acknowledge,
 * control byte and word address decode, page buffer, self-timed commit
 * and sequential read out of a 64K x 8 array.
 * Assumes SCL and SDA arrive asynchronously and far slower than REF_CLK;
 * the SDA wire is open drain and resolved outside from SDA_OE.
 */
`timescale 1ns/1ps
`default_nettype none
module seis_eeprom_slave
    import seis_pkg::*;
#(
    parameter logic [3:0] TYPE_CODE = 4'h5, // arbitrary device type value
    parameter int unsigned WC_LEN = seis_pkg::WC_CYCLES
)
(
    input wire logic REF_CLK,
    input wire logic ARST_N,
    input wire logic SCL,
    input wire logic SDA_I,
    output logic SDA_O,
    output logic SDA_OE,
    input wire logic [2:0] CHIP_SEL,
    input wire logic WRITE_PROTECT,
    output logic WRITE_BUSY
);
    import seis_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // pin synchronisers
    logic scl_m, scl_q, scl_p, sda_m, sda_q, sda_p, wp_m, wp_q;
    logic [2:0] cs_m, cs_q;
    seis_cond_t cond;

    // two flops per pin, then one more stage on SCL/SDA for edge detection
    always_ff @(posedge REF_CLK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            scl_m <= 1'b1;
            scl_q <= 1'b1;
            scl_p <= 1'b1;
            sda_m <= 1'b1;
            sda_q <= 1'b1;
            sda_p <= 1'b1;
            wp_m <= 1'b1;
            wp_q <= 1'b1;
            cs_m <= 3'h0;
            cs_q <= 3'h0;
        end
        else
        begin
            scl_m <= SCL;
            scl_q <= scl_m;
            scl_p <= scl_q;
            sda_m <= SDA_I;
            sda_q <= sda_m;
            sda_p <= sda_q;
            wp_m <= WRITE_PROTECT;
            wp_q <= wp_m;
            cs_m <= CHIP_SEL;
            cs_q <= cs_m;
        end
    end

    // sda edges with scl held high mark start and stop
    always_comb
    begin
        cond.start = scl_q && scl_p && sda_p && !sda_q; // RL2
        cond.stop = scl_q && scl_p && !sda_p && sda_q; // RL3
        cond.rise = scl_q && !scl_p;
        cond.fall = !scl_q && scl_p;
    end

    // engine state, declared ahead of the storage that reads it
    seis_phase_t phase_q, phase_d;
    logic [3:0] cnt_q, cnt_d;
    logic [7:0] rx_q, rx_d, tx_q, tx_d;
    logic [ADDR_W-1:0] addr_q, addr_d;
    logic [ADDR_W-PAGE_W-1:0] page_q, page_d;
    logic [PAGE_W-1:0] cidx_q, cidx_d;
    logic [PAGE_BYTES-1:0] valid_q, valid_d;
    logic [TIMER_W-1:0] timer_q, timer_d;
    logic ack_q, ack_d, drv_q, drv_d, mack_q, mack_d, pend_q, pend_d;
    logic busy_q, busy_d, oe_q, oe_d;

    ////////////////////////////////////////////////////////////////////////////
    // storage: array and page buffer
    logic [7:0] mem [0:(1<<ADDR_W)-1];
    logic [7:0] pbuf [0:PAGE_BYTES-1];
    logic buf_we;
    logic [7:0] mem_rd;

    assign mem_rd = mem[addr_q];

    // the buffer holds the page until stop, so an abandoned command never touches the array
    always_ff @(posedge REF_CLK)
    begin
        if (buf_we)
            pbuf[addr_q[PAGE_W-1:0]] <= rx_q; // RL17
        if (busy_q && valid_q[cidx_q])
            mem[{page_q, cidx_q}] <= pbuf[cidx_q]; // RL19
    end

    ////////////////////////////////////////////////////////////////////////////
    // protocol engine

    // control byte decode, also used by the checks
    function automatic logic ctrl_match(input logic [7:0] b, input logic [2:0] cs);
        ctrl_match = (b[7:4] == TYPE_CODE) && (b[3:1] == cs); // RL10
    endfunction

    // next-state logic; start and stop outrank any clock activity
    always_comb
    begin
        phase_d = phase_q;
        cnt_d = cnt_q;
        rx_d = rx_q;
        tx_d = tx_q;
        addr_d = addr_q;
        page_d = page_q;
        cidx_d = cidx_q;
        valid_d = valid_q;
        timer_d = timer_q;
        ack_d = ack_q;
        drv_d = drv_q;
        mack_d = mack_q;
        pend_d = pend_q;
        busy_d = busy_q;
        buf_we = 1'b0;
        // self-timed commit walks the page once per 128 cycles until the timer ends
        if (busy_q)
        begin
            timer_d = timer_q - 20'h00001; // RL23
            cidx_d = cidx_q + 7'h01;
            if (timer_q == 20'h00001)
                busy_d = 1'b0;
        end
        if (cond.start)
        begin
            phase_d = PH_CTRL; // RL25
            cnt_d = CNT_RST;
            ack_d = 1'b0;
            drv_d = 1'b0;
            pend_d = 1'b0;
        end
        else if (cond.stop)
        begin
            phase_d = PH_IDLE;
            cnt_d = CNT_RST;
            ack_d = 1'b0;
            drv_d = 1'b0;
            pend_d = 1'b0;
            // protect level taken here and nowhere else
            if (pend_q && !busy_q && !wp_q) // RL20 RL1
            begin
                busy_d = 1'b1; // RL14
                timer_d = TIMER_W'(WC_LEN);
                cidx_d = 7'h00;
                page_d = addr_q[ADDR_W-1:PAGE_W];
            end
        end
        else if (phase_q != PH_IDLE)
        begin
            if (cond.rise)
            begin
                if (cnt_q < BIT_ACK)
                    rx_d = {rx_q[6:0], sda_q}; // RL4
                if (cnt_q == BIT_ACK)
                    mack_d = !sda_q;
                if (cnt_q != BIT_END)
                    cnt_d = cnt_q + 4'h1;
            end
            else if (cond.fall)
            begin
                case (cnt_q)
                    BIT_ACK:
                    begin
                        // byte complete: decide the ninth bit
                        case (phase_q)
                            PH_CTRL:
                            begin
                                if (ctrl_match(rx_q, cs_q) && !busy_q) // RL11 RL24
                                begin
                                    ack_d = 1'b1; // RL6
                                    phase_d = rx_q[0] ? PH_RDAT : PH_AHI; // RL12
                                end
                                else
                                    phase_d = PH_IDLE; // RL7
                            end
                            PH_AHI:
                            begin
                                addr_d[15:8] = rx_q; // RL13
                                ack_d = 1'b1;
                                phase_d = PH_ALO;
                            end
                            PH_ALO:
                            begin
                                addr_d[7:0] = rx_q;
                                ack_d = 1'b1;
                                valid_d = '0;
                                phase_d = PH_WDAT;
                            end
                            PH_WDAT:
                            begin
                                // bytes kept even under protect; the stop decides
                                buf_we = 1'b1;
                                valid_d[addr_q[PAGE_W-1:0]] = 1'b1; // RL17
                                addr_d[PAGE_W-1:0] = addr_q[PAGE_W-1:0] + 7'h01; // RL18 RL16
                                pend_d = 1'b1; // RL14
                                ack_d = 1'b1; // RL15
                            end
                            PH_RDAT:
                                drv_d = 1'b0;
                            default:
                                phase_d = PH_IDLE;
                        endcase
                    end
                    BIT_END:
                    begin
                        ack_d = 1'b0;
                        cnt_d = CNT_RST;
                        if (phase_q == PH_RDAT)
                        begin
                            if (mack_q)
                            begin
                                tx_d = mem_rd;
                                drv_d = 1'b1;
                                addr_d = addr_q + 16'h0001; // RL22
                            end
                            else
                            begin
                                drv_d = 1'b0; // RL9
                                phase_d = PH_IDLE;
                            end
                        end
                    end
                    default:
                    begin
                        if (phase_q == PH_RDAT && drv_q && cnt_q != CNT_RST)
                            tx_d = {tx_q[6:0], 1'b0};
                    end
                endcase
            end
        end
        // open drain: only ever pull low
        oe_d = ack_d || (drv_d && !tx_d[7]); // RL8
    end

    // state registers
    always_ff @(posedge REF_CLK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            phase_q <= PH_IDLE;
            cnt_q <= CNT_RST;
            rx_q <= 8'h00;
            tx_q <= 8'hFF;
            addr_q <= ADDR_RST;
            page_q <= 9'h000;
            cidx_q <= 7'h00;
            valid_q <= '0;
            timer_q <= TIMER_RST;
            ack_q <= 1'b0;
            drv_q <= 1'b0;
            mack_q <= 1'b0;
            pend_q <= 1'b0;
            busy_q <= 1'b0;
            oe_q <= 1'b0;
        end
        else
        begin
            phase_q <= phase_d;
            cnt_q <= cnt_d;
            rx_q <= rx_d;
            tx_q <= tx_d;
            addr_q <= addr_d;
            page_q <= page_d;
            cidx_q <= cidx_d;
            valid_q <= valid_d;
            timer_q <= timer_d;
            ack_q <= ack_d;
            drv_q <= drv_d;
            mack_q <= mack_d;
            pend_q <= pend_d;
            busy_q <= busy_d;
            oe_q <= oe_d;
        end
    end

    assign SDA_O = 1'b0;
    assign SDA_OE = oe_q;
    assign WRITE_BUSY = busy_q;

    ////////////////////////////////////////////////////////////////////////////
    // checks
    logic [TIMER_W-1:0] run_q;

    // length of the current busy stretch
    always_ff @(posedge REF_CLK or negedge ARST_N)
    begin
        if (!ARST_N)
            run_q <= TIMER_RST;
        else
            run_q <= busy_q ? run_q + 20'h00001 : TIMER_RST;
    end

    default clocking cb @(posedge REF_CLK);
    endclocking
    default disable iff (!ARST_N);

    sequence s_byte_end;
        cond.fall && !cond.start && !cond.stop && cnt_q == BIT_ACK;
    endsequence
    sequence s_ctrl_hit;
        phase_q == PH_CTRL && !busy_q && ctrl_match(rx_q, cs_q);
    endsequence

    chk_busy_no_ack: assert property (s_byte_end ##0 (phase_q == PH_CTRL && busy_q) |=> !ack_q && phase_q == PH_IDLE) else $error("acknowledge while busy"); // RL7
    chk_ctrl_ack: assert property (s_byte_end ##0 s_ctrl_hit |=> ack_q && oe_q) else $error("matching control byte not acknowledged"); // RL11
    chk_rw_select: assert property (s_byte_end ##0 s_ctrl_hit |=> phase_q == ($past(rx_q[0]) ? PH_RDAT : PH_AHI)) else $error("wrong direction chosen"); // RL12
    chk_start_fresh: assert property (cond.start |=> phase_q == PH_CTRL && cnt_q == CNT_RST && !oe_q) else $error("start did not restart decode"); // RL25
    chk_stop_idle: assert property (cond.stop |=> phase_q == PH_IDLE && !oe_q) else $error("stop did not release the bus"); // RL3
    chk_wp_blocks: assert property (cond.stop && wp_q && !busy_q |=> !busy_q [*2]) else $error("protected write started a cycle"); // RL15
    chk_write_launch: assert property (cond.stop && pend_q && !wp_q && !busy_q |=> busy_q && timer_q == TIMER_W'(WC_LEN)) else $error("stop did not launch write"); // RL14
    chk_page_wrap: assert property (s_byte_end ##0 phase_q == PH_WDAT |=> addr_q[15:7] == $past(addr_q[15:7]) && addr_q[6:0] == 7'($past(addr_q[6:0]) + 7'h01)) else $error("pointer left the page"); // RL18
    chk_nack_release: assert property (cond.fall && !cond.stop && !cond.start && cnt_q == BIT_END && phase_q == PH_RDAT && !mack_q |=> !oe_q && phase_q == PH_IDLE) else $error("no release after master nack"); // RL9
    chk_busy_bound: assert property (run_q <= TIMER_W'(WC_LEN)) else $error("write cycle overran"); // RL23
    chk_ack_hold: assert property (ack_q && cond.rise && !cond.start && !cond.stop |=> ack_q && oe_q) else $error("acknowledge dropped in high phase"); // RL8
endmodule
`default_nettype wire

// *** hw/seis_pkg.sv ***
/*
 * Shared constants, types and state encoding for the two-wire serial
 * EEPROM slave front end with byte write, page write and sequential read.
 * Assumes a single 100 MHz system clock samples both bus pins.
 */
// Function
// RL1 - write-protect low permits array writes, high blocks them; reads stay working
// RL2 - SDA falling while SCL high is a start; master issues it, device detects
// RL3 - SDA rising while SCL high is a stop; master ends with it, device detects
// RL4 - SDA changes only while SCL low; one bit sampled per SCL high
// RL5 - master starts a transfer only when SDA and SCL both idle high
// RL6 - addressed receiver acknowledges each byte on the ninth clock the master gives
// RL7 - no acknowledge at all, control byte included, while programming runs
// RL8 - acknowledger holds SDA low through the whole ninth clock high phase
// RL9 - master NACKs the last read byte; device then releases SDA high
// RL10 - first byte after start is the control byte: type, three selects, direction
// RL11 - acknowledge control byte only on matching type code and chip-select pins
// RL12 - direction bit one selects read, zero selects write
// RL13 - two address bytes follow a write control byte, high byte first, all significant
// RL14 - byte write is control, address high, address low, data; stop launches programming
// RL15 - protected write still acknowledged, no programming, ready again at once
// RL16 - after a byte write the pointer holds the next location
// RL17 - up to 127 more bytes are buffered and committed only after stop
// RL18 - each data byte increments only the low seven pointer bits, wrapping past 128
// RL19 - page data wraps to the start of the same page, not the next one
// RL20 - write-protect sampled at stop; later changes do not alter that cycle
// RL21 - controller avoids page writes that would cross a page boundary
// RL22 - chip selects extend the address; sequential reads never cross devices
// RL23 - internal write cycle finishes within 5 ms after stop
// RL24 - poll by start plus write control byte; acknowledge only once the cycle ends
// RL25 - a start mid-command abandons it and decodes a fresh control byte
package seis_pkg;
    localparam int ADDR_W = 16;
    localparam int PAGE_W = 7;
    localparam int PAGE_BYTES = 128;
    localparam int T_WC_MS = 5;
    localparam int CLK_FREQ_KHZ = 100000;
    // longest time rounds down; 5 ms at 100 MHz
    localparam int WC_CYCLES = T_WC_MS * CLK_FREQ_KHZ;
    localparam int TIMER_W = 20;
    localparam logic [3:0] BIT_ACK = 4'h8;
    localparam logic [3:0] BIT_END = 4'h9;
    localparam logic [3:0] CNT_RST = 4'h0;
    localparam logic [ADDR_W-1:0] ADDR_RST = 16'h0000;
    localparam logic [TIMER_W-1:0] TIMER_RST = 20'h00000;

    typedef enum logic [2:0] {PH_IDLE, PH_CTRL, PH_AHI, PH_ALO, PH_WDAT, PH_RDAT} seis_phase_t;

    // bus conditions seen on the synchronised pins
    typedef struct packed {
        logic start;
        logic stop;
        logic rise;
        logic fall;
    } seis_cond_t;
endpackage

// *** tb/seis_bus_master.sv ***
/*
 * Behavioural two-wire bus master that owns the serial clock and the
 * start and stop conditions, for driving the EEPROM slave.
 * Assumes the bench resolves the data wire with a pull-up from both enables.
 */
`timescale 1ns/1ps
`default_nettype none
module seis_bus_master
(
    input wire logic clk,
    input wire logic sda_in,
    output logic scl,
    output logic sda_oe
);
    // a quarter of the 160 ns bus clock at 100 MHz
    localparam int QTR = 4;
    ////////////////////////////////////////////////////////////////
    // idle bus: both lines high, clock stands still between frames
    initial
    begin
        scl = 1'b1;
        sda_oe = 1'b0;
    end
    task automatic qw();
        repeat (QTR) @(posedge clk);
    endtask
    // data is released first so a repeated start cannot look like a stop
    task automatic start();
        sda_oe <= 1'b0;
        qw();
        scl <= 1'b1;
        qw();
        sda_oe <= 1'b1;
        qw();
        scl <= 1'b0;
        qw();
    endtask
    task automatic stop();
        sda_oe <= 1'b1;
        qw();
        scl <= 1'b1;
        qw();
        sda_oe <= 1'b0;
        qw();
    endtask
    // data moves a quarter after the clock falls; sampled mid high phase
    task automatic clk_bit(input logic b, output logic s);
        sda_oe <= ~b;
        qw();
        scl <= 1'b1;
        qw();
        s = sda_in;
        qw();
        scl <= 1'b0;
        qw();
    endtask
    task automatic send_byte(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--)
            clk_bit(d[i], s);
        clk_bit(1'b1, s);
        ack = ~s;
    endtask
    // last byte gets no acknowledge so the slave lets go of the wire
    task automatic recv_byte(input logic last, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--)
            clk_bit(1'b1, d[i]);
        clk_bit(last, s);
    endtask
endmodule
`default_nettype wire

// *** tb/tb.sv ***
/*
 * Self-checking bench for the serial EEPROM slave: addressing, byte and
 * page writes, wrap, write protect, polling and aborted commands.
 * Assumes the package, the slave and the bus master model compile first.
 */
`timescale 1ns/1ps
`default_nettype none
module tb;
    import seis_pkg::*;
    localparam logic [3:0] CODE = 4'h9; // arbitrary device type value
    localparam logic [2:0] SEL = 3'h5;
    localparam int WC = 200;
    logic ref_clk;
    logic arst_n;
    logic scl;
    logic m_oe;
    logic sda_o;
    logic sda_oe;
    logic wp;
    logic busy;
    logic [2:0] chip_sel;
    wire logic sda;
    int miscompares = 0;
    int n_checks = 0;
    // open-drain wire with pull-up
    assign sda = ~(m_oe | sda_oe);
    ////////////////////////////////////////////////////////////////
    seis_eeprom_slave #(.TYPE_CODE(CODE), .WC_LEN(WC)) seis_eeprom_slave_inst (
        .REF_CLK(ref_clk), .ARST_N(arst_n), .SCL(scl), .SDA_I(sda), .SDA_O(sda_o),
        .SDA_OE(sda_oe), .CHIP_SEL(chip_sel), .WRITE_PROTECT(wp), .WRITE_BUSY(busy));
    seis_bus_master mst (.clk(ref_clk), .sda_in(sda), .scl(scl), .sda_oe(m_oe));
    initial
    begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    ////////////////////////////////////////////////////////////////
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("[ERR] t=%0t seen=%0h exp=%0h", $time, seen, exp);
        end
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // start plus control byte, acknowledge compared
    task automatic ctrl(input logic [7:0] c, input logic exp);
        logic k;
        mst.start();
        mst.send_byte(c, k);
        check(8'(k), 8'(exp));
    endtask
    task automatic write_seq(input logic [15:0] a, input int n, input logic [7:0] d0);
        logic k;
        ctrl({CODE, SEL, 1'b0}, 1'b1);
        for (int i = 0; i < n + 2; i++)
        begin
            mst.send_byte(i == 0 ? a[15:8] : i == 1 ? a[7:0] : d0 + 8'(i - 2), k);
            check(8'(k), 8'h01);
        end
        mst.stop();
    endtask
    // random read of up to four bytes, expected bytes packed msb first
    task automatic read_seq(input logic [15:0] a, input int n, input logic [31:0] e);
        logic [7:0] d;
        logic k;
        ctrl({CODE, SEL, 1'b0}, 1'b1);
        mst.send_byte(a[15:8], k);
        mst.send_byte(a[7:0], k);
        ctrl({CODE, SEL, 1'b1}, 1'b1);
        for (int i = 0; i < n; i++)
        begin
            mst.recv_byte(i == n - 1, d);
            check(d, e[31 - 8 * i -: 8]);
        end
        mst.stop();
    endtask
    // launch seen soon after stop, polled while busy, bounded wait for the end
    task automatic expect_write(input logic yes);
        int t;
        t = 0;
        // step off the launching edge before looking at the flag
        @(negedge ref_clk);
        while (busy !== 1'b1 && t < 20)
        begin
            @(negedge ref_clk);
            t++;
        end
        check(8'(busy), 8'(yes));
        if (yes)
        begin
            ctrl({CODE, SEL, 1'b0}, 1'b0);
            mst.stop();
        end
        t = 0;
        while (busy !== 1'b0 && t < WC + 50)
        begin
            @(negedge ref_clk);
            t++;
        end
        check(8'(busy), 8'h00);
        if (busy !== 1'b0)
            give_verdict();
        ctrl({CODE, SEL, 1'b0}, 1'b1);
        mst.stop();
    endtask
    ////////////////////////////////////////////////////////////////
    task automatic s_bad_ctrl();
        ctrl({CODE ^ 4'h1, SEL, 1'b0}, 1'b0);
        check(8'(sda_o), 8'h00);
        mst.stop();
        ctrl({CODE, SEL ^ 3'h2, 1'b1}, 1'b0);
        mst.stop();
    endtask
    task automatic s_byte_write();
        logic [7:0] d;
        write_seq(16'h3457, 1, 8'h3C);
        expect_write(1'b1);
        write_seq(16'h3456, 1, 8'hC3);
        expect_write(1'b1);
        ctrl({CODE, SEL, 1'b1}, 1'b1);
        mst.recv_byte(1'b1, d);
        check(d, 8'h3C);
        mst.stop();
        read_seq(16'h3456, 2, 32'hC33C0000);
    endtask
    task automatic s_page();
        write_seq(16'h217D, 6, 8'h40);
        expect_write(1'b1);
        read_seq(16'h217D, 3, 32'h40414200);
        read_seq(16'h2100, 3, 32'h43444500);
        write_seq(16'h2200, 130, 8'h00);
        expect_write(1'b1);
        read_seq(16'h2200, 3, 32'h80810200);
    endtask
    task automatic s_protect();
        wp <= 1'b1;
        write_seq(16'h3456, 2, 8'h00);
        expect_write(1'b0);
        read_seq(16'h3456, 1, 32'hC3000000);
        wp <= 1'b0;
        write_seq(16'h3458, 1, 8'h77);
        wp <= 1'b1;
        expect_write(1'b1);
        read_seq(16'h3458, 1, 32'h77000000);
        wp <= 1'b0;
    endtask
    // repeated start in mid write drops the buffered byte
    task automatic s_abort();
        logic [7:0] d;
        logic k;
        ctrl({CODE, SEL, 1'b0}, 1'b1);
        mst.send_byte(8'h34, k);
        mst.send_byte(8'h56, k);
        mst.send_byte(8'h11, k);
        ctrl({CODE, SEL, 1'b1}, 1'b1);
        mst.recv_byte(1'b1, d);
        mst.stop();
        expect_write(1'b0);
        read_seq(16'h3456, 1, 32'hC3000000);
    endtask
    ////////////////////////////////////////////////////////////////
    initial
    begin
        arst_n = 1'b0;
        wp = 1'b0;
        chip_sel = SEL;
        repeat (8) @(posedge ref_clk);
        arst_n <= 1'b1;
        repeat (4) @(posedge ref_clk);
        s_bad_ctrl();
        s_byte_write();
        s_page();
        s_protect();
        s_abort();
        give_verdict();
    end
endmodule
`default_nettype wire
